// ### hw/plc_system_area_drive_reference.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Operation
// - User-fault instruction code is kept in a sixteen-bit system word.
// - Largest scan duration seen so far is kept.
// - Smallest scan duration seen so far is kept.
// - Duration of the latest scan is kept.
// - Four calendar words shown, valid only with clock module fitted.
// - Program step of the latest error is kept.
// - Forcing acts only while the forced-I/O enable bit is set.
// - Per I/O word a select register and a value register drive forcing.
// - With clock module, stop records of date, time and code follow pointer.
// - History holds sixteen four-word records after the pointer word.
// - Seventeenth stop overwrites the oldest record.
// - Frequency command word goes to the drive, hertz times 100.
// - Drive operating state is mirrored into the status monitor word.
// - Drive output frequency is mirrored into the monitor word.
// - Frequency command is ignored if a write-data parameter targets 0x0380.
// - Command bits: run, forward, rising fault reset, coast stop edges.
// - Operation command is ignored if a write-data parameter targets 0x0382.
module plc_system_area_drive_reference #(
  parameter int SCAN_UNIT_CYCLES = sysarea_pkg::SCAN_UNIT_CYC
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  input  wire logic [7:0]                 regAddr,
  input  wire logic [15:0]                regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [15:0]                regRdata,
  input  wire logic                       scanEnd,
  input  wire logic                       userFaultEvt,
  input  wire logic [15:0]                userFaultCode,
  input  wire logic                       errStepEvt,
  input  wire logic [15:0]                errStep,
  input  wire logic                       rtcPresent,
  input  wire sysarea_pkg::calendar_t     calendar,
  input  wire logic                       stopEvt,
  input  wire logic [15:0]                stopCode,
  input  wire logic [1:0][15:0]           ioRaw,
  output logic      [1:0][15:0]           ioForced,
  input  wire logic [4:0][15:0]           wrDataAddr,
  input  wire sysarea_pkg::drive_mon_t    driveMon,
  output sysarea_pkg::drive_cmd_t         driveCmd,
  output logic                            irq
);

  function automatic logic paramTargets(input logic [4:0][15:0] p, input logic [15:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < sysarea_pkg::WR_PARAMS; i++) begin
      if (p[i] == a) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Fault reset and coast stop bits are judged on edges between two consecutive cycles of the word
  function automatic logic bitRose(input logic [15:0] cur, input logic [15:0] prev, input int b);
    return cur[b] && !prev[b];
  endfunction

  function automatic logic bitFell(input logic [15:0] cur, input logic [15:0] prev, input int b);
    return !cur[b] && prev[b];
  endfunction

  // No clock module fitted: calendar words read as zero rather than stale values
  function automatic logic [15:0] calWord(input logic present, input logic [15:0] w);
    return present ? w : sysarea_pkg::WORD_ZERO;
  endfunction

  // Scan count stops at full scale so an overlong scan cannot wrap to a small value
  function automatic logic [15:0] satInc(input logic [15:0] v);
    return (v == sysarea_pkg::WORD_ONES) ? v : v + 16'h1;
  endfunction

  logic [15:0] userFault_q;
  logic [15:0] scanMax_q;
  logic [15:0] scanMin_q;
  logic [15:0] scanNow_q;
  logic [15:0] scanCnt_q;
  logic [31:0] unitCnt_q;
  logic        seenScan_q;
  logic [15:0] errStep_q;
  logic        forceEn_q;
  logic [1:0][15:0] fsel_q;
  logic [1:0][15:0] fval_q;
  logic [15:0] freqCmd_q;
  logic [15:0] opCmd_q;
  logic [15:0] opPrev_q;
  logic [15:0] drvStatus_q;
  logic [15:0] drvOutFreq_q;
  logic [15:0] hist_q [0:sysarea_pkg::HIST_RECORDS*sysarea_pkg::HIST_WORDS-1];
  logic [3:0]  histIdx_q;
  logic        histAny_q;
  logic [sysarea_pkg::IRQ_BITS-1:0] irqStat_q;
  logic [sysarea_pkg::IRQ_BITS-1:0] irqMask_q;
  logic [sysarea_pkg::IRQ_BITS-1:0] irqEvt;
  logic        wr;
  logic        unitTick;
  logic        newMax;
  logic [15:0] scanDone;
  logic        freqBlocked;
  logic        opBlocked;
  logic        histWrite;
  logic [3:0]  histNext;
  logic [15:0] histPtrWord;
  logic [15:0] readMux;
  logic [7:0]  histOff;

  assign wr          = regWrite;
  assign unitTick    = (unitCnt_q == 32'(SCAN_UNIT_CYCLES - 1));
  // A unit that completes on the closing edge still belongs to the scan just ended
  assign scanDone    = unitTick ? satInc(scanCnt_q) : scanCnt_q;
  assign newMax      = scanEnd && (!seenScan_q || scanDone > scanMax_q);
  assign freqBlocked = paramTargets(wrDataAddr, sysarea_pkg::DRV_ADDR_FREQ);
  assign opBlocked   = paramTargets(wrDataAddr, sysarea_pkg::DRV_ADDR_OP);
  assign histWrite   = stopEvt && rtcPresent;
  assign histNext    = histAny_q ? histIdx_q + 4'h1 : 4'h0;
  assign histPtrWord = histAny_q ? 16'({1'b0, histIdx_q} + 5'h01) : sysarea_pkg::WORD_ZERO;
  assign histOff     = regAddr - sysarea_pkg::A_HIST_FIRST;

  // User fault code and error step
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      userFault_q <= sysarea_pkg::WORD_ZERO;
      errStep_q   <= sysarea_pkg::WORD_ZERO;
    end else begin
      if (userFaultEvt) begin
        userFault_q <= userFaultCode;
      end
      if (errStepEvt) begin
        errStep_q <= errStep;
      end
    end
  end

  // Scan timing; counter saturates so an overlong scan reads as full scale
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      unitCnt_q  <= '0;
      scanCnt_q  <= sysarea_pkg::WORD_ZERO;
      scanNow_q  <= sysarea_pkg::WORD_ZERO;
      scanMax_q  <= sysarea_pkg::WORD_ZERO;
      scanMin_q  <= sysarea_pkg::WORD_ONES;
      seenScan_q <= 1'b0;
    end else begin
      unitCnt_q <= (unitTick || scanEnd) ? '0 : unitCnt_q + 32'h1;
      if (scanEnd) begin
        scanNow_q  <= scanDone;
        seenScan_q <= 1'b1;
        scanCnt_q  <= sysarea_pkg::WORD_ZERO;
        if (newMax) begin
          scanMax_q <= scanDone;
        end
        if (!seenScan_q || scanDone < scanMin_q) begin
          scanMin_q <= scanDone;
        end
      end else if (unitTick) begin
        scanCnt_q <= satInc(scanCnt_q);
      end
    end
  end

  // Forcing registers and enable
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      forceEn_q <= 1'b0;
      fsel_q    <= '0;
      fval_q    <= '0;
    end else if (wr) begin
      case (regAddr)
        sysarea_pkg::A_CONTROL: forceEn_q <= regWdata[sysarea_pkg::CTL_FORCE_EN];
        sysarea_pkg::A_FSEL0:   fsel_q[0] <= regWdata;
        sysarea_pkg::A_FSEL4:   fsel_q[1] <= regWdata;
        sysarea_pkg::A_FVAL0:   fval_q[0] <= regWdata;
        sysarea_pkg::A_FVAL4:   fval_q[1] <= regWdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ioForced <= '0;
    end else begin
      for (int w = 0; w < 2; w++) begin
        if (forceEn_q) begin
          ioForced[w] <= (ioRaw[w] & ~fsel_q[w]) | (fval_q[w] & fsel_q[w]);
        end else begin
          ioForced[w] <= ioRaw[w];
        end
      end
    end
  end

  // Drive command words written by the program
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      freqCmd_q <= sysarea_pkg::WORD_ZERO;
      opCmd_q   <= sysarea_pkg::WORD_ZERO;
    end else if (wr) begin
      if (regAddr == sysarea_pkg::A_FREQ_CMD) begin
        freqCmd_q <= regWdata;
      end
      if (regAddr == sysarea_pkg::A_OP_CMD) begin
        opCmd_q <= regWdata;
      end
    end
  end

  // Previous command word, tracked even while blocked
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      opPrev_q <= sysarea_pkg::WORD_ZERO;
    end else begin
      opPrev_q <= opCmd_q;
    end
  end

  // Edges are judged only while the path is live, so unblocking does not fire stale edges
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      driveCmd <= '0;
    end else begin
      driveCmd.freqValid <= !freqBlocked;
      driveCmd.freqRef   <= freqBlocked ? sysarea_pkg::WORD_ZERO : freqCmd_q;
      driveCmd.cmdValid  <= !opBlocked;
      driveCmd.faultReset <= 1'b0;
      if (!opBlocked) begin
        driveCmd.run     <= opCmd_q[sysarea_pkg::OP_RUN];
        driveCmd.forward <= opCmd_q[sysarea_pkg::OP_FWD];
        driveCmd.faultReset <= bitRose(opCmd_q, opPrev_q, sysarea_pkg::OP_FRST);
        if (bitRose(opCmd_q, opPrev_q, sysarea_pkg::OP_COAST)) begin
          driveCmd.coastStop <= 1'b1;
        end else if (bitFell(opCmd_q, opPrev_q, sysarea_pkg::OP_COAST)) begin
          driveCmd.coastStop <= 1'b0;
        end
      end else begin
        driveCmd.run       <= 1'b0;
        driveCmd.forward   <= 1'b0;
        driveCmd.coastStop <= 1'b0;
      end
    end
  end

  // Drive monitor mirror
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      drvStatus_q  <= sysarea_pkg::WORD_ZERO;
      drvOutFreq_q <= sysarea_pkg::WORD_ZERO;
    end else begin
      drvStatus_q  <= driveMon.status;
      drvOutFreq_q <= driveMon.outFreq;
    end
  end

  // Stop history ring; records are not cleared by reset, only the pointer is
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      histIdx_q <= 4'h0;
      histAny_q <= 1'b0;
    end else if (histWrite) begin
      histIdx_q <= histNext;
      histAny_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (histWrite) begin
      hist_q[{histNext, sysarea_pkg::REC_YM}]   <= calendar.yearMonth;
      hist_q[{histNext, sysarea_pkg::REC_DH}]   <= calendar.dayHour;
      hist_q[{histNext, sysarea_pkg::REC_MS}]   <= calendar.minSec;
      hist_q[{histNext, sysarea_pkg::REC_CODE}] <= stopCode;
    end
  end

  // Interrupts: set wins over a write-one clear in the same cycle
  assign irqEvt[sysarea_pkg::IRQ_FAULT]   = userFaultEvt;
  assign irqEvt[sysarea_pkg::IRQ_STOP]    = histWrite;
  assign irqEvt[sysarea_pkg::IRQ_NEW_MAX] = newMax;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irqStat_q <= '0;
      irqMask_q <= '0;
      irq       <= 1'b0;
    end else begin
      if (wr && regAddr == sysarea_pkg::A_IRQ_STATUS) begin
        irqStat_q <= (irqStat_q & ~regWdata[sysarea_pkg::IRQ_BITS-1:0]) | irqEvt;
      end else begin
        irqStat_q <= irqStat_q | irqEvt;
      end
      if (wr && regAddr == sysarea_pkg::A_IRQ_MASK) begin
        irqMask_q <= regWdata[sysarea_pkg::IRQ_BITS-1:0];
      end
      irq <= |(irqStat_q & irqMask_q);
    end
  end

  // Read decode
  always_comb begin
    readMux = sysarea_pkg::WORD_ZERO;
    case (regAddr)
      sysarea_pkg::A_USER_FAULT:  readMux = userFault_q;
      sysarea_pkg::A_SCAN_MAX:    readMux = scanMax_q;
      sysarea_pkg::A_SCAN_MIN:    readMux = scanMin_q;
      sysarea_pkg::A_SCAN_NOW:    readMux = scanNow_q;
      sysarea_pkg::A_CAL_YM:      readMux = calWord(rtcPresent, calendar.yearMonth);
      sysarea_pkg::A_CAL_DH:      readMux = calWord(rtcPresent, calendar.dayHour);
      sysarea_pkg::A_CAL_MS:      readMux = calWord(rtcPresent, calendar.minSec);
      sysarea_pkg::A_CAL_CW:      readMux = calWord(rtcPresent, calendar.centWeekday);
      sysarea_pkg::A_ERR_STEP:    readMux = errStep_q;
      sysarea_pkg::A_CONTROL:     readMux = 16'({forceEn_q});
      sysarea_pkg::A_IRQ_STATUS:  readMux = 16'(irqStat_q);
      sysarea_pkg::A_IRQ_MASK:    readMux = 16'(irqMask_q);
      sysarea_pkg::A_FREQ_CMD:    readMux = freqCmd_q;
      sysarea_pkg::A_OP_CMD:      readMux = opCmd_q;
      sysarea_pkg::A_DRV_STATUS:  readMux = drvStatus_q;
      sysarea_pkg::A_DRV_OUTFREQ: readMux = drvOutFreq_q;
      sysarea_pkg::A_FSEL0:       readMux = fsel_q[0];
      sysarea_pkg::A_FSEL4:       readMux = fsel_q[1];
      sysarea_pkg::A_FVAL0:       readMux = fval_q[0];
      sysarea_pkg::A_FVAL4:       readMux = fval_q[1];
      sysarea_pkg::A_HIST_PTR:    readMux = histPtrWord;
      default: begin
        if (regAddr >= sysarea_pkg::A_HIST_FIRST && regAddr <= sysarea_pkg::A_HIST_LAST) begin
          readMux = hist_q[histOff[5:0]];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      regRdata <= sysarea_pkg::WORD_ZERO;
    end else if (regRead) begin
      regRdata <= readMux;
    end else begin
      regRdata <= sysarea_pkg::WORD_ZERO;
    end
  end

endmodule // plc_system_area_drive_reference

// ### shared/sysarea_pkg.sv
package sysarea_pkg;
  // Word index on the register port
  localparam logic [7:0] A_USER_FAULT  = 8'h00;
  localparam logic [7:0] A_SCAN_MAX    = 8'h01;
  localparam logic [7:0] A_SCAN_MIN    = 8'h02;
  localparam logic [7:0] A_SCAN_NOW    = 8'h03;
  localparam logic [7:0] A_CAL_YM      = 8'h04;
  localparam logic [7:0] A_CAL_DH      = 8'h05;
  localparam logic [7:0] A_CAL_MS      = 8'h06;
  localparam logic [7:0] A_CAL_CW      = 8'h07;
  localparam logic [7:0] A_ERR_STEP    = 8'h08;
  localparam logic [7:0] A_CONTROL     = 8'h10;
  localparam logic [7:0] A_IRQ_STATUS  = 8'h11;
  localparam logic [7:0] A_IRQ_MASK    = 8'h12;
  localparam logic [7:0] A_FREQ_CMD    = 8'h20;
  localparam logic [7:0] A_OP_CMD      = 8'h21;
  localparam logic [7:0] A_DRV_STATUS  = 8'h22;
  localparam logic [7:0] A_DRV_OUTFREQ = 8'h23;
  localparam logic [7:0] A_FSEL0       = 8'h30;
  localparam logic [7:0] A_FSEL4       = 8'h31;
  localparam logic [7:0] A_FVAL0       = 8'h32;
  localparam logic [7:0] A_FVAL4       = 8'h33;
  localparam logic [7:0] A_HIST_PTR    = 8'h40;
  localparam logic [7:0] A_HIST_FIRST  = 8'h41;
  localparam logic [7:0] A_HIST_LAST   = 8'h80;

  localparam int         HIST_RECORDS  = 16;
  localparam int         HIST_WORDS    = 4;
  localparam logic [1:0] REC_YM        = 2'h0;
  localparam logic [1:0] REC_DH        = 2'h1;
  localparam logic [1:0] REC_MS        = 2'h2;
  localparam logic [1:0] REC_CODE      = 2'h3;

  // Control register bit
  localparam int CTL_FORCE_EN = 0;
  // Interrupt status/mask bits
  localparam int IRQ_FAULT   = 0;
  localparam int IRQ_STOP    = 1;
  localparam int IRQ_NEW_MAX = 2;
  localparam int IRQ_BITS    = 3;
  // Operation command bits
  localparam int OP_RUN   = 0;
  localparam int OP_FWD   = 1;
  localparam int OP_FRST  = 2;
  localparam int OP_COAST = 3;

  // Drive common addresses that steal the fixed paths
  localparam logic [15:0] DRV_ADDR_FREQ = 16'h0380;
  localparam logic [15:0] DRV_ADDR_OP   = 16'h0382;
  localparam int          WR_PARAMS     = 5;

  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;

  // Scan time is counted in units of 0.1 ms
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCAN_UNIT_NS  = 100000;
  localparam int SCAN_UNIT_CYC = SCAN_UNIT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [15:0] yearMonth;
    logic [15:0] dayHour;
    logic [15:0] minSec;
    logic [15:0] centWeekday;
  } calendar_t;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] outFreq;
  } drive_mon_t;

  typedef struct packed {
    logic [15:0] freqRef;
    logic        freqValid;
    logic        cmdValid;
    logic        run;
    logic        forward;
    logic        faultReset;
    logic        coastStop;
  } drive_cmd_t;
endpackage

// ### verification/drive_model.sv
`timescale 1ns/1ps
// Drive side: mirrors what it was commanded into its state and output frequency.
module drive_model (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire sysarea_pkg::drive_cmd_t driveCmd,
  output sysarea_pkg::drive_mon_t      driveMon
);
  logic going;
  assign going = driveCmd.cmdValid && driveCmd.run && !driveCmd.coastStop;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      driveMon <= '0;
    end else begin
      // Forward or reverse at constant speed, zero when stopped
      driveMon.status <= going ? (driveCmd.forward ? 16'h0031 : 16'h0032) : 16'h0000;
      driveMon.outFreq <= (going && driveCmd.freqValid) ? driveCmd.freqRef : 16'h0000;
    end
  end
endmodule // drive_model

// ### verification/sysarea_properties.sv
`timescale 1ns/1ps
module sysarea_properties (
  input wire logic                    sys_clk,
  input wire logic                    rstn,
  input wire logic [7:0]              regAddr,
  input wire logic [15:0]             regWdata,
  input wire logic                    regWrite,
  input wire logic                    regRead,
  input wire logic [15:0]             regRdata,
  input wire logic                    userFaultEvt,
  input wire logic [15:0]             userFaultCode,
  input wire logic                    errStepEvt,
  input wire logic [15:0]             errStep,
  input wire logic                    rtcPresent,
  input wire logic [1:0][15:0]        ioRaw,
  input wire logic [1:0][15:0]        ioForced,
  input wire logic [4:0][15:0]        wrDataAddr,
  input wire sysarea_pkg::drive_cmd_t driveCmd
);
  logic [15:0] faultCode_q;
  logic [15:0] step_q;
  logic        forceEn_q;
  logic        blockFreq;
  logic        blockOp;
  always_comb begin
    blockFreq = 1'b0;
    blockOp = 1'b0;
    for (int i = 0; i < 5; i++) begin
      blockFreq |= wrDataAddr[i] == sysarea_pkg::DRV_ADDR_FREQ;
      blockOp |= wrDataAddr[i] == sysarea_pkg::DRV_ADDR_OP;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) faultCode_q <= 16'h0000;
    else if (userFaultEvt) faultCode_q <= userFaultCode;
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) step_q <= 16'h0000;
    else if (errStepEvt) step_q <= errStep;
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) forceEn_q <= 1'b0;
    else if (regWrite && regAddr == sysarea_pkg::A_CONTROL)
      forceEn_q <= regWdata[sysarea_pkg::CTL_FORCE_EN];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  user_fault_a: assert property (
    regRead && regAddr == sysarea_pkg::A_USER_FAULT |=> regRdata == $past(faultCode_q))
    else $error("user fault word differs from last code");
  err_step_a: assert property (
    regRead && regAddr == sysarea_pkg::A_ERR_STEP |=> regRdata == $past(step_q))
    else $error("error step word differs from last step");
  cal_blank_a: assert property (
    regRead && regAddr inside {[sysarea_pkg::A_CAL_YM:sysarea_pkg::A_CAL_CW]}
    && !rtcPresent && $past(!rtcPresent) |=> regRdata == 16'h0000)
    else $error("calendar shown without clock module");
  ptr_range_a: assert property (
    regRead && regAddr == sysarea_pkg::A_HIST_PTR |=> regRdata <= 16'h0010)
    else $error("history pointer beyond sixteen");
  force_off_a: assert property (
    !forceEn_q |=> ioForced == $past(ioRaw))
    else $error("forcing active while disabled");
  freq_block_a: assert property (
    blockFreq [*2] |-> driveCmd.freqRef == 16'h0000 && !driveCmd.freqValid)
    else $error("frequency path not blocked");
  op_block_a: assert property (
    blockOp [*3] |-> !driveCmd.cmdValid && !driveCmd.run && !driveCmd.forward
    && !driveCmd.faultReset && !driveCmd.coastStop)
    else $error("operation path not blocked");
  fault_pulse_a: assert property (
    driveCmd.faultReset |=> !driveCmd.faultReset)
    else $error("fault reset longer than one cycle");
endmodule // sysarea_properties
bind plc_system_area_drive_reference sysarea_properties i_sysarea_properties (
  .sys_clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .userFaultEvt,
  .userFaultCode, .errStepEvt, .errStep, .rtcPresent, .ioRaw, .ioForced, .wrDataAddr,
  .driveCmd);

// ### verification/plc_system_area_drive_reference_bench.sv
`timescale 1ns/1ps
module plc_system_area_drive_reference_bench;
  logic                    sys_clk = 1'b0;
  logic                    rstn = 1'b0;
  logic [7:0]              regAddr = 8'h00;
  logic [15:0]             regWdata = 16'h0000;
  logic                    regWrite = 1'b0;
  logic                    regRead = 1'b0;
  logic [15:0]             regRdata;
  logic                    scanEnd = 1'b0;
  logic                    userFaultEvt = 1'b0;
  logic [15:0]             userFaultCode = 16'h0000;
  logic                    errStepEvt = 1'b0;
  logic [15:0]             errStep = 16'h0000;
  logic                    rtcPresent = 1'b0;
  sysarea_pkg::calendar_t  calendar = '0;
  logic                    stopEvt = 1'b0;
  logic [15:0]             stopCode = 16'h0000;
  logic [1:0][15:0]        ioRaw = '0;
  logic [1:0][15:0]        ioForced;
  logic [4:0][15:0]        wrDataAddr = '0;
  sysarea_pkg::drive_mon_t driveMon;
  sysarea_pkg::drive_cmd_t driveCmd;
  logic                    irq;
  logic [15:0]             rdv;
  int                      miscompares = 0;
  int                      checksDone = 0;
  always #4 sys_clk = ~sys_clk;
  // Short scan unit keeps the scan-time figures small
  plc_system_area_drive_reference #(.SCAN_UNIT_CYCLES(4)) i_plc_system_area_drive_reference (
    .sys_clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .scanEnd,
    .userFaultEvt, .userFaultCode, .errStepEvt, .errStep, .rtcPresent, .calendar, .stopEvt,
    .stopCode, .ioRaw, .ioForced, .wrDataAddr, .driveMon, .driveCmd, .irq);
  drive_model i_drive_model (.sys_clk, .rstn, .driveCmd, .driveMon);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task automatic t_scan();
    rd(sysarea_pkg::A_SCAN_MIN);
    check(rdv, 16'hFFFF);
    tick(60);
    // Gaps of 40, 80 and 20 cycles are 10, 20 and 5 whole units of four cycles
    for (int g = 0; g < 4; g++) begin
      scanEnd <= 1'b1;
      tick(1);
      scanEnd <= 1'b0;
      if (g < 3) tick(g == 0 ? 39 : (g == 1 ? 79 : 19));
    end
    wr(sysarea_pkg::A_SCAN_MAX, 16'h1234);
    rd(sysarea_pkg::A_SCAN_MAX);
    check(rdv, 16'h0014);
    rd(sysarea_pkg::A_SCAN_MIN);
    check(rdv, 16'h0005);
    rd(sysarea_pkg::A_SCAN_NOW);
    check(rdv, 16'h0005);
  endtask
  task automatic t_fault();
    userFaultCode <= 16'h0A5C;
    errStep <= 16'h0123;
    userFaultEvt <= 1'b1;
    errStepEvt <= 1'b1;
    tick(1);
    userFaultEvt <= 1'b0;
    errStepEvt <= 1'b0;
    tick(2);
    check(irq, 16'h0000);
    rd(sysarea_pkg::A_USER_FAULT);
    check(rdv, 16'h0A5C);
    rd(sysarea_pkg::A_ERR_STEP);
    check(rdv, 16'h0123);
    rd(sysarea_pkg::A_IRQ_STATUS);
    check(rdv, 16'h0005);
    wr(sysarea_pkg::A_IRQ_MASK, 16'h0001);
    tick(2);
    check(irq, 16'h0001);
    wr(sysarea_pkg::A_IRQ_STATUS, 16'h0001);
    tick(2);
    check(irq, 16'h0000);
    rd(sysarea_pkg::A_IRQ_STATUS);
    check(rdv, 16'h0004);
  endtask
  task automatic t_cal();
    calendar <= {16'h2409, 16'h1513, 16'h3042, 16'h2003};
    rd(sysarea_pkg::A_CAL_YM);
    check(rdv, 16'h0000);
    rtcPresent <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(sysarea_pkg::A_CAL_YM + 8'(i));
      check(rdv, calendar[63-16*i -: 16]);
    end
  endtask
  task automatic t_hist();
    rtcPresent <= 1'b0;
    stopEvt <= 1'b1;
    tick(1);
    stopEvt <= 1'b0;
    rd(sysarea_pkg::A_HIST_PTR);
    check(rdv, 16'h0000);
    rtcPresent <= 1'b1;
    for (int i = 1; i <= 17; i++) begin
      calendar.yearMonth <= 16'(i);
      stopCode <= 16'h0E00 + 16'(i);
      stopEvt <= 1'b1;
      tick(1);
      stopEvt <= 1'b0;
      tick(1);
      if (i == 16) rd(sysarea_pkg::A_HIST_PTR);
      if (i == 16) check(rdv, 16'h0010);
    end
    rd(sysarea_pkg::A_HIST_PTR);
    check(rdv, 16'h0001);
    rd(sysarea_pkg::A_HIST_FIRST + 8'h03);
    check(rdv, 16'h0E11);
    rd(sysarea_pkg::A_HIST_FIRST + 8'h07);
    check(rdv, 16'h0E02);
    rd(sysarea_pkg::A_HIST_LAST - 8'h03);
    check(rdv, 16'h0010);
    rd(sysarea_pkg::A_HIST_LAST);
    check(rdv, 16'h0E10);
  endtask
  task automatic t_force();
    ioRaw <= {16'h1234, 16'h00FF};
    wr(sysarea_pkg::A_FSEL0, 16'h0F0F);
    wr(sysarea_pkg::A_FVAL0, 16'hAAAA);
    wr(sysarea_pkg::A_FSEL4, 16'hFF00);
    wr(sysarea_pkg::A_FVAL4, 16'h5600);
    tick(2);
    check(ioForced[0], 16'h00FF);
    wr(sysarea_pkg::A_CONTROL, 16'h0001);
    tick(2);
    check(ioForced[0], 16'h0AFA);
    check(ioForced[1], 16'h5634);
    rd(sysarea_pkg::A_FSEL4);
    check(rdv, 16'hFF00);
    rd(8'hF0);
    check(rdv, 16'h0000);
  endtask
  task automatic t_drive();
    logic [15:0] n;
    n = 16'h0000;
    wr(sysarea_pkg::A_FREQ_CMD, 16'h0BB8);
    wr(sysarea_pkg::A_OP_CMD, 16'h0003);
    tick(4);
    check(driveCmd.freqRef, 16'h0BB8);
    check({14'h0, driveCmd.run, driveCmd.forward}, 16'h0003);
    rd(sysarea_pkg::A_DRV_STATUS);
    check(rdv, 16'h0031);
    rd(sysarea_pkg::A_DRV_OUTFREQ);
    check(rdv, 16'h0BB8);
    wrDataAddr[2] <= sysarea_pkg::DRV_ADDR_FREQ;
    tick(4);
    check({driveCmd.freqRef[14:0], driveCmd.freqValid}, 16'h0000);
    wrDataAddr[2] <= 16'h0000;
    tick(4);
    check(driveCmd.freqRef, 16'h0BB8);
    check({15'h0, driveCmd.freqValid}, 16'h0001);
    wr(sysarea_pkg::A_OP_CMD, 16'h0007);
    repeat (8) begin
      tick(1);
      n = n + 16'(driveCmd.faultReset);
    end
    check(n, 16'h0001);
    wr(sysarea_pkg::A_OP_CMD, 16'h000B);
    tick(4);
    check(driveCmd.coastStop, 16'h0001);
    wr(sysarea_pkg::A_OP_CMD, 16'h0002);
    tick(4);
    check({driveCmd.coastStop, driveCmd.run}, 16'h0000);
    wrDataAddr[4] <= sysarea_pkg::DRV_ADDR_OP;
    wr(sysarea_pkg::A_OP_CMD, 16'h0003);
    tick(4);
    check({driveCmd.cmdValid, driveCmd.run}, 16'h0000);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    miscompares++;
    give_verdict();
  end
  initial begin
    tick(20);
    rstn <= 1'b1;
    t_scan();
    t_fault();
    t_cal();
    t_hist();
    t_force();
    t_drive();
    give_verdict();
  end
endmodule // plc_system_area_drive_reference_bench
